// [include/bwe_defines.svh]
// Command codes, register addresses, field positions and reset values
`ifndef BWE_DEFINES_SVH
`define BWE_DEFINES_SVH

`define BWE_CMD_REG_READ      8'h65
`define BWE_CMD_REG_WRITE     8'h71
`define BWE_CMD_SET_BURST     8'hC0
`define BWE_CMD_ECC_READ_A    8'h18
`define BWE_CMD_ECC_READ_B    8'h19

`define BWE_ADDR_CONFIG_BOOT  24'h000004
`define BWE_ADDR_CONFIG_LIVE  24'h800004

`define BWE_CONFIG_RESET      8'h10
`define BWE_CONFIG_WMASK      8'hF3
`define BWE_ECC_RESET         8'h00

`define BWE_WRAP_DIS_BIT      4
`define BWE_WRAP_LEN_HI       1
`define BWE_WRAP_LEN_LO       0
`define BWE_DRIVE_HI          7
`define BWE_DRIVE_LO          5

`define BWE_ADDR_BYTES_LAST   2'h2
`define BWE_BIT_LAST          3'h7

`endif

// [include/bwe_pkg.sv]
// Types for the burst wrap configuration and ecc status block
package bwe_pkg;

   typedef enum logic [2:0] {
      BWE_PH_CMD,
      BWE_PH_ADDR,
      BWE_PH_WDATA,
      BWE_PH_LOAD,
      BWE_PH_RDATA,
      BWE_PH_DONE
   } bwe_phase_type;

   typedef enum logic [1:0] {
      BWE_RD_ARRAY_QUAD,
      BWE_RD_ARRAY_OTHER,
      BWE_RD_NON_ARRAY
   } bwe_read_kind_type;

   typedef struct packed {
      logic [2:0]    sck_sync;
      logic [2:0]    cs_sync;
      logic [2:0]    si_sync;
      logic          sck_st;
      logic          cs_n_st;
      logic          si_st;
      bwe_phase_type phase;
      logic [7:0]    shift;
      logic [2:0]    bit_cnt;
      logic [1:0]    byte_cnt;
      logic [7:0]    cmd;
      logic [23:0]   addr;
      logic [7:0]    config_boot;
      logic [7:0]    config_live;
      logic [7:0]    tx;
      logic          so;
      logic          so_oe;
      logic [23:0]   ecc_unit_addr;
      logic [31:0]   burst_addr;
      logic          wrap_active;
      logic [5:0]    wrap_mask;
   } bwe_state_type;

endpackage

// [sim/bwe_assertions.sv]
// Port checks for the burst wrap and ecc status block
`timescale 1ns/1ps
`default_nettype none
module bwe_assertions (
   input wire logic                       mclk,
   input wire logic                       rst_n,
   input wire logic                       soft_reset,
   input wire logic                       sck,
   input wire logic                       cs_n,
   input wire logic                       so_oe,
   input wire logic [23:0]                ecc_unit_addr,
   input wire logic                       burst_start,
   input wire logic [31:0]                burst_start_addr,
   input wire bwe_pkg::bwe_read_kind_type burst_kind,
   input wire logic                       burst_next,
   input wire logic [31:0]                burst_addr,
   input wire logic [2:0]                 drive_strength_live,
   input wire logic [1:0]                 wrap_length_live,
   input wire logic                       wrap_disabled_live
);
   logic        wrap_on;
   logic [31:0] mask;
   // Burst mode is latched at start, as the design does
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrap_on <= 1'b0;
         mask    <= 32'h7;
      end else if (burst_start) begin
         wrap_on <= (burst_kind == bwe_pkg::BWE_RD_ARRAY_QUAD)
                    && !wrap_disabled_live;
         mask    <= (32'h8 << wrap_length_live) - 32'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_deselected;
      cs_n [*6];
   endsequence
   a_reset_state: assert property (
      $rose(rst_n) |-> !so_oe && burst_addr == 32'h0 && {drive_strength_live,
      wrap_disabled_live, wrap_length_live} == 6'h04)
      else $error("bad state after reset");
   a_start_loads: assert property (
      burst_start |=> burst_addr == $past(burst_start_addr))
      else $error("burst start not loaded");
   a_wrap_step: assert property (
      !burst_start && burst_next && wrap_on |=> burst_addr ==
      (($past(burst_addr) & ~mask) | (($past(burst_addr) + 32'h1) & mask)))
      else $error("bad wrapped step");
   a_seq_step: assert property (
      !burst_start && burst_next && !wrap_on |=>
      burst_addr == $past(burst_addr) + 32'h1)
      else $error("bad sequential step");
   a_addr_hold: assert property (
      !burst_start && !burst_next |=> $stable(burst_addr))
      else $error("burst address moved");
   a_ecc_in_frame: assert property (
      $changed(ecc_unit_addr) |-> !cs_n)
      else $error("ecc unit moved outside frame");
   a_oe_rise: assert property (
      $rose(so_oe) |-> !cs_n && !sck)
      else $error("enable rose at wrong time");
   a_oe_drop: assert property (
      s_deselected |-> !so_oe)
      else $error("enable held after deselect");
   a_live_cause: assert property (
      $changed({drive_strength_live, wrap_disabled_live, wrap_length_live})
      |-> !cs_n || $past(soft_reset) || $past(soft_reset, 2))
      else $error("live config changed alone");
endmodule
`default_nettype wire

// [sim/bwe_host_model.sv]
// Serial host controller model issuing mode 0 frames
`timescale 1ns/1ps
`default_nettype none
module bwe_host_model (
   input  wire logic mclk,
   input  wire logic so,
   input  wire logic so_oe,
   output var  logic sck,
   output var  logic cs_n,
   output var  logic si
);
   int half = 8;
   logic so_seen;
   // A released line shows the inverse, so a missing enable is caught
   assign so_seen = so_oe ? so : ~so;
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   // command, address, data, then read byte
   task automatic frame(input logic [63:0] d, input int nb,
                        output logic [7:0] rd);
      int k;
      @(posedge mclk) cs_n <= 1'b0;
      for (k = 0; k < nb + 8; k++) begin
         @(posedge mclk) si <= (k < nb) ? d[63-k] : ~si;
         // The edge above counts toward the low half of the period
         repeat (half - 1) @(posedge mclk);
         sck <= 1'b1;
         if (k >= nb) rd = {rd[6:0], so_seen};
         repeat (half) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (8) @(posedge mclk);
      cs_n <= 1'b1;
      si   <= ~si;
      repeat (8) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the burst wrap and ecc status block
`timescale 1ns/1ps
`default_nettype none
`include "bwe_defines.svh"
module tb_top;
   logic        mclk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0;
   logic        code_c = 1'b0, data_c = 1'b0, dis_c = 1'b0;
   logic        bstart = 1'b0, bnext = 1'b0, sck, cs_n, si, so, so_oe, wdis;
   logic [31:0] bstart_a = 32'h0, baddr;
   logic [23:0] ecc_a;
   logic [7:0]  rd;
   logic [2:0]  drv;
   logic [1:0]  wlen;
   int          i, n_mismatch = 0, samples_checked = 0;
   bwe_pkg::bwe_read_kind_type kind = bwe_pkg::BWE_RD_NON_ARRAY;
   always #5 mclk = ~mclk;
   bwe_burst_wrap_ecc dut (.mclk(mclk), .rst_n(rst_n),
      .soft_reset(soft_reset), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
      .so_oe(so_oe), .ecc_unit_addr(ecc_a), .code_bit_corrected(code_c),
      .data_bit_corrected(data_c), .correction_disabled(dis_c),
      .burst_start(bstart), .burst_start_addr(bstart_a), .burst_kind(kind),
      .burst_next(bnext), .burst_addr(baddr), .drive_strength_live(drv),
      .wrap_length_live(wlen), .wrap_disabled_live(wdis));
   bwe_host_model host (.mclk(mclk), .so(so), .so_oe(so_oe), .sck(sck),
      .cs_n(cs_n), .si(si));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic rd_cfg(input logic [23:0] a, input logic [7:0] exp);
      host.frame({`BWE_CMD_REG_READ, a, 32'h0}, 32, rd);
      check(rd, exp);
   endtask
   task automatic wr_cfg(input logic [23:0] a, input logic [7:0] d);
      host.frame({`BWE_CMD_REG_WRITE, a, d, 24'h0}, 40, rd);
   endtask
   task automatic burst(input bwe_pkg::bwe_read_kind_type k,
                        input logic [31:0] a, input logic [31:0] exp);
      @(posedge mclk);
      bstart   <= 1'b1;
      kind     <= k;
      bstart_a <= a;
      @(posedge mclk);
      bstart <= 1'b0;
      bnext  <= 1'b1;
      @(posedge mclk);
      bnext <= 1'b0;
      @(posedge mclk);
      check(baddr, exp);
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_cfg(`BWE_ADDR_CONFIG_BOOT, 8'h10);
      rd_cfg(`BWE_ADDR_CONFIG_LIVE, 8'h10);
      check({drv, wdis, wlen}, 6'h04);
      rd_cfg(24'h000005, 8'h00);
      wr_cfg(`BWE_ADDR_CONFIG_LIVE, 8'hFF);
      rd_cfg(`BWE_ADDR_CONFIG_LIVE, 8'hF3);
      for (i = 0; i < 4; i++) begin
         host.frame({`BWE_CMD_SET_BURST, 6'h38, i[1:0], 48'h0}, 16,
                    rd);
         check({drv, wdis, wlen}, {3'h7, 1'b0, i[1:0]});
         burst(bwe_pkg::BWE_RD_ARRAY_QUAD, 32'h0FFF + (32'h8 << i),
               32'h1000);
      end
      burst(bwe_pkg::BWE_RD_ARRAY_QUAD, 32'h1025, 32'h1026);
      burst(bwe_pkg::BWE_RD_ARRAY_OTHER, 32'h103F, 32'h1040);
      burst(bwe_pkg::BWE_RD_NON_ARRAY, 32'h103F, 32'h1040);
      rd_cfg(`BWE_ADDR_CONFIG_BOOT, 8'h10);
      wr_cfg(`BWE_ADDR_CONFIG_BOOT, 8'h5A);
      rd_cfg(`BWE_ADDR_CONFIG_BOOT, 8'h52);
      check({drv, wdis, wlen}, {3'h7, 1'b0, 2'h3});
      soft_reset <= 1'b1;
      @(posedge mclk) soft_reset <= 1'b0;
      repeat (3) @(posedge mclk);
      check({drv, wdis, wlen}, {3'h2, 1'b1, 2'h2});
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_cfg(`BWE_ADDR_CONFIG_LIVE, 8'h10);
      // Odd units use the alternate ecc read code
      for (i = 0; i < 8; i++) begin
         {code_c, data_c, dis_c} <= i[2:0];
         host.frame({i[0] ? `BWE_CMD_ECC_READ_B : `BWE_CMD_ECC_READ_A,
                     16'h0100, i[7:0], 32'h0}, 32, rd);
         check(rd[2:0], i[2:0]);
         check(ecc_a, {16'h0100, i[7:0]});
      end
      wrap_up;
   end
endmodule
bind bwe_burst_wrap_ecc bwe_assertions u_chk (.mclk(mclk), .rst_n(rst_n),
   .soft_reset(soft_reset), .sck(sck), .cs_n(cs_n), .so_oe(so_oe),
   .ecc_unit_addr(ecc_unit_addr), .burst_start(burst_start),
   .burst_start_addr(burst_start_addr), .burst_kind(burst_kind),
   .burst_next(burst_next), .burst_addr(burst_addr),
   .drive_strength_live(drive_strength_live),
   .wrap_length_live(wrap_length_live),
   .wrap_disabled_live(wrap_disabled_live));
`default_nettype wire

// [verilog/bwe_burst_wrap_ecc.sv]
// Burst wrap configuration and ecc status registers behind a serial port
`timescale 1ns/1ps
`default_nettype none
`include "bwe_defines.svh"

// Function
// - Wrap applies only to main array reads
// - Soft reset copies boot config into live config; hard reset loads 10h into both
// - Both copies reached by generic read/write
// - Set burst length writes live copy only
// - Bit 4 zero wraps, boot default one
// - Only quad reads may wrap
// - Bits 1:0 pick 8/16/32/64 byte wrap
// - Bits 7:5 drive strength, live adjustable
// - Ecc read takes unit address, returns status
// - Status bit 2 flags corrected code bit
// - Status bit 1 flags corrected data bit
// - Status bit 0 flags correction disabled
// - Ecc status read only, defaults zero
module bwe_burst_wrap_ecc (
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire logic                       soft_reset,
   input  wire logic                       sck,
   input  wire logic                       cs_n,
   input  wire logic                       si,
   output logic                            so,
   output logic                            so_oe,
   output logic [23:0]                     ecc_unit_addr,
   input  wire logic                       code_bit_corrected,
   input  wire logic                       data_bit_corrected,
   input  wire logic                       correction_disabled,
   input  wire logic                       burst_start,
   input  wire logic [31:0]                burst_start_addr,
   input  wire bwe_pkg::bwe_read_kind_type burst_kind,
   input  wire logic                       burst_next,
   output logic [31:0]                     burst_addr,
   output logic [2:0]                      drive_strength_live,
   output logic [1:0]                      wrap_length_live,
   output logic                            wrap_disabled_live
);

   bwe_pkg::bwe_state_type st;
   bwe_pkg::bwe_state_type next_st;

   // Mask of the low address bits that circle inside one wrap group
   function automatic logic [5:0] wrap_group_mask(input logic [1:0] len);
      logic [5:0] m;
      m = 6'h07;
      unique case (len)
         2'h0: m = 6'h07;
         2'h1: m = 6'h0F;
         2'h2: m = 6'h1F;
         2'h3: m = 6'h3F;
      endcase
      return m;
   endfunction

   function automatic logic is_ecc_cmd(input logic [7:0] c);
      return (c == `BWE_CMD_ECC_READ_A) || (c == `BWE_CMD_ECC_READ_B);
   endfunction

   // A level counts only once the second and third stages agree
   function automatic logic settle(input logic [2:0] s, input logic cur);
      logic v;
      v = cur;
      if (s[1] == s[2]) begin
         v = s[2];
      end
      return v;
   endfunction

   // Unknown codes idle until deselect
   function automatic bwe_pkg::bwe_phase_type phase_after_cmd(
      input logic [7:0] c
   );
      bwe_pkg::bwe_phase_type p;
      p = bwe_pkg::BWE_PH_DONE;
      if (c == `BWE_CMD_REG_READ || c == `BWE_CMD_REG_WRITE ||
          is_ecc_cmd(c)) begin
         p = bwe_pkg::BWE_PH_ADDR;
      end else if (c == `BWE_CMD_SET_BURST) begin
         p = bwe_pkg::BWE_PH_WDATA;
      end
      return p;
   endfunction

   // Reads have no dummy cycles, so the answer is loaded at once
   function automatic bwe_pkg::bwe_phase_type phase_after_addr(
      input logic [7:0] c
   );
      bwe_pkg::bwe_phase_type p;
      p = bwe_pkg::BWE_PH_LOAD;
      if (c == `BWE_CMD_REG_WRITE) begin
         p = bwe_pkg::BWE_PH_WDATA;
      end
      return p;
   endfunction

   // Reserved bits 3:2 always store zero
   function automatic logic [7:0] masked(input logic [7:0] d);
      return d & `BWE_CONFIG_WMASK;
   endfunction

   // Hardware flags only
   // Reserved upper bits read zero rather than stale values
   function automatic logic [7:0] status_byte(input logic [2:0] f);
      return {5'h00, f};
   endfunction

   function automatic logic [2:0] drive_of(input logic [7:0] cfg);
      return cfg[`BWE_DRIVE_HI:`BWE_DRIVE_LO];
   endfunction

   function automatic logic [1:0] wrap_len_of(input logic [7:0] cfg);
      return cfg[`BWE_WRAP_LEN_HI:`BWE_WRAP_LEN_LO];
   endfunction

   function automatic logic wrap_off_of(input logic [7:0] cfg);
      return cfg[`BWE_WRAP_DIS_BIT];
   endfunction

   // Upper address bits never move inside a wrapped burst
   function automatic logic [31:0] wrap_step(
      input logic [31:0] a,
      input logic [5:0]  m
   );
      logic [5:0] low;
      low = (a[5:0] + 6'h01) & m;
      return {a[31:6], (a[5:0] & ~m) | low};
   endfunction

   // Unmapped register addresses read as zero
   function automatic logic [7:0] read_value(
      input logic [7:0]  c,
      input logic [23:0] a,
      input logic [7:0]  boot,
      input logic [7:0]  live,
      input logic [2:0]  flags
   );
      logic [7:0] v;
      v = 8'h00;
      if (is_ecc_cmd(c)) begin
         v = status_byte(flags);
      end else if (a == `BWE_ADDR_CONFIG_BOOT) begin
         v = boot;
      end else if (a == `BWE_ADDR_CONFIG_LIVE) begin
         v = live;
      end
      return v;
   endfunction

   logic       sck_rise;
   logic       sck_fall;
   logic [7:0] rx_byte;
   logic [2:0] ecc_flags;

   always_comb begin
      next_st = st;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      rx_byte = {st.shift[6:0], st.si_st};
      ecc_flags = {code_bit_corrected, data_bit_corrected,
                   correction_disabled};

      // Three stage sampling of the pins
      next_st.sck_sync = {st.sck_sync[1:0], sck};
      next_st.cs_sync = {st.cs_sync[1:0], cs_n};
      next_st.si_sync = {st.si_sync[1:0], si};
      next_st.sck_st = settle(st.sck_sync, st.sck_st);
      next_st.cs_n_st = settle(st.cs_sync, st.cs_n_st);
      next_st.si_st = settle(st.si_sync, st.si_st);
      sck_rise = next_st.sck_st && !st.sck_st;
      sck_fall = !next_st.sck_st && st.sck_st;

      if (st.cs_n_st) begin
         next_st.phase = bwe_pkg::BWE_PH_CMD;
         next_st.bit_cnt = 3'h0;
         next_st.byte_cnt = 2'h0;
         next_st.so_oe = 1'b0;
         next_st.so = 1'b0;
      end else begin
         if (sck_rise) begin
            next_st.shift = rx_byte;
            next_st.bit_cnt = st.bit_cnt + 3'h1;
         end
         unique case (st.phase)
            bwe_pkg::BWE_PH_CMD: begin
               if (sck_rise && st.bit_cnt == `BWE_BIT_LAST) begin
                  next_st.cmd = rx_byte;
                  next_st.byte_cnt = 2'h0;
                  next_st.phase = phase_after_cmd(rx_byte);
               end
            end
            bwe_pkg::BWE_PH_ADDR: begin
               if (sck_rise && st.bit_cnt == `BWE_BIT_LAST) begin
                  next_st.addr = {st.addr[15:0], rx_byte};
                  next_st.byte_cnt = st.byte_cnt + 2'h1;
                  if (st.byte_cnt == `BWE_ADDR_BYTES_LAST) begin
                     if (is_ecc_cmd(st.cmd)) begin
                        next_st.ecc_unit_addr = {st.addr[15:0], rx_byte};
                     end
                     next_st.phase = phase_after_addr(st.cmd);
                  end
               end
            end
            bwe_pkg::BWE_PH_WDATA: begin
               if (sck_rise && st.bit_cnt == `BWE_BIT_LAST) begin
                  next_st.phase = bwe_pkg::BWE_PH_DONE;
                  if (st.cmd == `BWE_CMD_SET_BURST) begin
                     next_st.config_live = masked(rx_byte);
                  end else if (st.addr == `BWE_ADDR_CONFIG_BOOT) begin
                     next_st.config_boot = masked(rx_byte);
                  end else if (st.addr == `BWE_ADDR_CONFIG_LIVE) begin
                     next_st.config_live = masked(rx_byte);
                  end
               end
            end
            bwe_pkg::BWE_PH_LOAD: begin
               next_st.tx = read_value(st.cmd, st.addr, st.config_boot,
                                       st.config_live, ecc_flags);
               next_st.phase = bwe_pkg::BWE_PH_RDATA;
            end
            bwe_pkg::BWE_PH_RDATA: begin
               // Byte repeats until deselect
               if (sck_fall) begin
                  next_st.so = st.tx[7];
                  next_st.so_oe = 1'b1;
                  next_st.tx = {st.tx[6:0], st.tx[7]};
               end
            end
            bwe_pkg::BWE_PH_DONE: begin
            end
         endcase
      end

      if (burst_start) begin
         next_st.burst_addr = burst_start_addr;
         next_st.wrap_active =
            (burst_kind == bwe_pkg::BWE_RD_ARRAY_QUAD) &&
            !wrap_off_of(st.config_live);
         next_st.wrap_mask = wrap_group_mask(wrap_len_of(st.config_live));
      end else if (burst_next) begin
         if (st.wrap_active) begin
            next_st.burst_addr = wrap_step(st.burst_addr, st.wrap_mask);
         end else begin
            next_st.burst_addr = st.burst_addr + 32'h1;
         end
      end

      if (soft_reset) begin
         next_st.config_live = st.config_boot;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st.sck_sync <= 3'h0;
         st.cs_sync <= 3'h7;
         st.si_sync <= 3'h0;
         st.sck_st <= 1'b0;
         // Deselected from the start, so no false frame follows reset
         st.cs_n_st <= 1'b1;
         st.si_st <= 1'b0;
         st.phase <= bwe_pkg::BWE_PH_CMD;
         st.shift <= 8'h00;
         st.bit_cnt <= 3'h0;
         st.byte_cnt <= 2'h0;
         st.cmd <= 8'h00;
         st.addr <= 24'h000000;
         st.config_boot <= `BWE_CONFIG_RESET;
         st.config_live <= `BWE_CONFIG_RESET;
         st.tx <= 8'h00;
         st.so <= 1'b0;
         st.so_oe <= 1'b0;
         st.ecc_unit_addr <= 24'h000000;
         st.burst_addr <= 32'h00000000;
         st.wrap_active <= 1'b0;
         st.wrap_mask <= 6'h07;
      end else begin
         st <= next_st;
      end
   end

   assign so = st.so;
   assign so_oe = st.so_oe;
   assign ecc_unit_addr = st.ecc_unit_addr;
   assign burst_addr = st.burst_addr;
   assign drive_strength_live = drive_of(st.config_live);
   assign wrap_length_live = wrap_len_of(st.config_live);
   assign wrap_disabled_live = wrap_off_of(st.config_live);

endmodule
`default_nettype wire
